// file: design/layer_mixer_defines.svh
// Constants for the layer keying mixer
`ifndef LAYER_MIXER_DEFINES_SVH
`define LAYER_MIXER_DEFINES_SVH
`define LM_REG_LAYER_ASSIGN    8'h04
`define LM_LAYER_MODE_SELECT_LSB         0
`define LM_LAYER_MODE_SELECT_W           4
`define LM_CTRL_RESET          8'h00
`define LM_BYPASS_MODE_MIN     4'h8
`define LM_PIX_W               24
`define LM_BUS_W               8
`define LM_OVL_W               5
`define LM_OVL_NONE            5'h00
`endif

// file: design/layer_mixer_pkg.sv
// Types for the layer keying mixer
package layer_mixer_pkg;
	`include "layer_mixer_defines.svh"
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_PD   = 3'b001,
		SRC_RGB  = 3'b010,
		SRC_YUV  = 3'b011,
		SRC_BUS  = 3'b100,
		SRC_OVL  = 3'b101
	} src_t;
	typedef enum logic [2:0] {
		KEY_NONE = 3'b000,
		KEY_PIN  = 3'b001,
		KEY_DATA = 3'b010,
		KEY_EITH = 3'b011,
		KEY_BYP  = 3'b100,
		KEY_OVL  = 3'b101
	} keysel_t;
	typedef struct packed {
		src_t    src;
		keysel_t key;
	} layer_t;
	typedef struct packed {
		layer_t dsk;
		layer_t fg;
		layer_t mg;
		src_t   bg;
	} arrange_t;
	typedef struct packed {
		logic [23:0] pixelPortData;
		logic [7:0]  busData;
		logic [4:0]  overlaySelectInputs;
		logic        keyPin;
		logic        dataKey;
		logic        bypassN;
	} pix_in_t;
	typedef struct packed {
		src_t        src;
		logic [23:0] data;
		logic [4:0]  overlay;
	} pix_out_t;
endpackage : layer_mixer_pkg

// file: design/layer_mixer.sv
// Per-pixel four-layer keying mixer with layer-assign register
`timescale 1ns/1ps
`include "layer_mixer_defines.svh"
// Functional notes
// - Downstream key beats foreground, which beats midground, which beats background.
// - The layer-mode field of the layer-assign register picks one of fourteen arrangements.
// - The overlay layer is opaque when any overlay select input is set, else transparent.
// - No arrangement ever puts the overlay on the background.
// - The bus may sit on any layer and when above background is keyed by key pin or data key, by key pin only in modes 2, 3, 6 and 7.
// - In modes 0 to 7 pixel data passes the lookup path and the bypass input is ignored.
// - A low key shows the layer image and a high key shows what lies beneath.
// - The layer choice is made afresh for every pixel.
// - Keys come from the key pin, from the internal data-key comparator input, or from the bypass input for the YCbCr layer in modes 9 to F.
// - In two-layer use bus data is keyed over pixel data by key pin or data key.
// - Modes 0 to 3 follow their fixed arrangements of pixel data, bus and overlay.
// - Modes 9 to F split pixel data into RGB and bypass-keyed YCbCr layers.
// - In modes 8 to F a high bypass input disables the data key.
module layer_mixer
	import layer_mixer_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic        regWrite,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	output logic      [7:0]  regRdata,
	// Pixel input stream
	input  wire logic        inValid,
	output logic             inReady,
	input  wire pix_in_t     pixIn,
	// Pixel output stream
	output logic             outValid,
	input  wire logic        outReady,
	output pix_out_t         pixOut
);
	logic [7:0] ctrl_q, ctrl_d;
	logic       pckEn_q, pckEn_d;
	logic [3:0] layerMode;
	arrange_t   arr;
	pix_out_t   mixed;

	assign layerMode = ctrl_q[`LM_LAYER_MODE_SELECT_LSB +: `LM_LAYER_MODE_SELECT_W];

	function automatic layer_t lay(input src_t s, input keysel_t k);
		lay = '{src: s, key: k};
	endfunction : lay

	// Arrangement table; the overlay never appears as bg
	always_comb begin
		arr = '{dsk: lay(SRC_NONE, KEY_NONE), fg: lay(SRC_NONE, KEY_NONE),
			mg: lay(SRC_NONE, KEY_NONE), bg: SRC_PD};
		case (layerMode)
			4'h0: begin
				arr.mg = lay(SRC_BUS, KEY_EITH);
			end
			4'h1: begin
				arr.mg = lay(SRC_BUS, KEY_EITH);
				arr.fg = lay(SRC_OVL, KEY_OVL);
			end
			4'h2, 4'h3: begin
				arr.mg  = lay(SRC_BUS, KEY_PIN);
				arr.fg  = lay(SRC_PD, KEY_DATA);
				arr.dsk = lay(SRC_OVL, KEY_OVL);
			end
			4'h4: begin
				arr.bg = SRC_BUS;
				arr.mg = lay(SRC_OVL, KEY_OVL);
				arr.fg = lay(SRC_PD, KEY_EITH);
			end
			4'h5: begin
				arr.bg = SRC_BUS;
				arr.mg = lay(SRC_PD, KEY_EITH);
				arr.fg = lay(SRC_OVL, KEY_OVL);
			end
			4'h6, 4'h7: begin
				arr.mg  = lay(SRC_BUS, KEY_PIN);
				arr.fg  = lay(SRC_OVL, KEY_OVL);
				arr.dsk = lay(SRC_PD, KEY_DATA);
			end
			4'h8: begin
				arr.bg = SRC_YUV;
				arr.mg = lay(SRC_BUS, KEY_EITH);
			end
			4'h9: begin
				arr.bg  = SRC_RGB;
				arr.mg  = lay(SRC_YUV, KEY_BYP);
				arr.fg  = lay(SRC_BUS, KEY_EITH);
				arr.dsk = lay(SRC_OVL, KEY_OVL);
			end
			4'hA: begin
				arr.bg  = SRC_RGB;
				arr.mg  = lay(SRC_BUS, KEY_EITH);
				arr.fg  = lay(SRC_YUV, KEY_BYP);
				arr.dsk = lay(SRC_OVL, KEY_OVL);
			end
			4'hB: begin
				arr.bg  = SRC_RGB;
				arr.mg  = lay(SRC_BUS, KEY_EITH);
				arr.fg  = lay(SRC_OVL, KEY_OVL);
				arr.dsk = lay(SRC_YUV, KEY_BYP);
			end
			4'hC: begin
				arr.bg  = SRC_RGB;
				arr.mg  = lay(SRC_YUV, KEY_BYP);
				arr.fg  = lay(SRC_OVL, KEY_OVL);
				arr.dsk = lay(SRC_BUS, KEY_EITH);
			end
			4'hD: begin
				arr.bg  = SRC_BUS;
				arr.mg  = lay(SRC_RGB, KEY_PIN);
				arr.fg  = lay(SRC_YUV, KEY_BYP);
				arr.dsk = lay(SRC_OVL, KEY_OVL);
			end
			4'hE: begin
				arr.bg  = SRC_BUS;
				arr.mg  = lay(SRC_OVL, KEY_OVL);
				arr.fg  = lay(SRC_RGB, KEY_PIN);
				arr.dsk = lay(SRC_YUV, KEY_BYP);
			end
			4'hF: begin
				arr.bg  = SRC_RGB;
				arr.mg  = lay(SRC_OVL, KEY_OVL);
				arr.fg  = lay(SRC_BUS, KEY_EITH);
				arr.dsk = lay(SRC_YUV, KEY_BYP);
			end
			default: begin
				arr.bg = SRC_PD;
			end
		endcase
	end

	// Active-low key: 0 shows the layer
	function automatic logic keyShows(input keysel_t k, input pix_in_t p, input logic [3:0] m);
		logic dk;
		dk = p.dataKey & ~((m >= `LM_BYPASS_MODE_MIN) & p.bypassN);
		case (k)
			KEY_PIN:  keyShows = ~p.keyPin;
			KEY_DATA: keyShows = ~dk;
			KEY_EITH: keyShows = ~(p.keyPin | dk);
			KEY_BYP:  keyShows = ~p.bypassN & (m >= `LM_BYPASS_MODE_MIN);
			KEY_OVL:  keyShows = (p.overlaySelectInputs != `LM_OVL_NONE);
			default:  keyShows = 1'b0;
		endcase
	endfunction : keyShows

	function automatic logic [23:0] srcData(input src_t s, input pix_in_t p);
		case (s)
			SRC_PD, SRC_RGB, SRC_YUV: srcData = p.pixelPortData;
			SRC_BUS: srcData = {16'h0000, p.busData};
			default: srcData = 24'h00_0000;
		endcase
	endfunction : srcData

	// Layer key states, shared by the resolver and its checks
	logic dskOn;
	logic fgOn;
	logic mgOn;
	assign dskOn = (arr.dsk.src != SRC_NONE) && keyShows(arr.dsk.key, pixIn, layerMode);
	assign fgOn  = (arr.fg.src != SRC_NONE) && keyShows(arr.fg.key, pixIn, layerMode);
	assign mgOn  = (arr.mg.src != SRC_NONE) && keyShows(arr.mg.key, pixIn, layerMode);

	// Priority resolve, evaluated per pixel
	always_comb begin
		mixed.overlay = pixIn.overlaySelectInputs;
		if (dskOn) begin
			mixed.src = arr.dsk.src;
		end else if (fgOn) begin
			mixed.src = arr.fg.src;
		end else if (mgOn) begin
			mixed.src = arr.mg.src;
		end else begin
			mixed.src = arr.bg;
		end
		mixed.data = srcData(mixed.src, pixIn);
	end

	// Two-entry skid buffer so a stalled receiver loses no pixel
	pix_out_t   buf_q [2];
	pix_out_t   buf_d [2];
	logic [1:0] cnt_q, cnt_d;
	logic       push, pop;

	assign inReady  = pckEn_q && (cnt_q != 2'd2);
	assign outValid = (cnt_q != 2'd0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign pixOut   = buf_q[0];

	always_comb begin
		buf_d = buf_q;
		cnt_d = cnt_q;
		if (pop) begin
			buf_d[0] = buf_q[1];
		end
		if (push) begin
			buf_d[(cnt_q - (pop ? 2'd1 : 2'd0)) == 2'd0 ? 0 : 1] = mixed;
		end
		cnt_d = cnt_q + (push ? 2'd1 : 2'd0) - (pop ? 2'd1 : 2'd0);
	end

	// Register port and pixel-rate enable
	always_comb begin
		ctrl_d  = ctrl_q;
		pckEn_d = ~pckEn_q;
		if (regWrite && regAddr == `LM_REG_LAYER_ASSIGN) begin
			ctrl_d = regWdata;
		end
	end

	always_comb begin
		regRdata = (regAddr == `LM_REG_LAYER_ASSIGN) ? ctrl_q : 8'h00;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q   <= `LM_CTRL_RESET;
			pckEn_q  <= 1'b0;
			cnt_q    <= 2'd0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else begin
			ctrl_q   <= ctrl_d;
			pckEn_q  <= pckEn_d;
			cnt_q    <= cnt_d;
			buf_q[0] <= buf_d[0];
			buf_q[1] <= buf_d[1];
		end
	end

	// Checks
	property p_noOvlBg;
		@(posedge mclk) disable iff (!rst_n) arr.bg != SRC_OVL;
	endproperty
	a_noOvlBg: assert property (p_noOvlBg) else $error("overlay on background");

	property p_bypIgnored;
		@(posedge mclk) disable iff (!rst_n)
			(layerMode < 4'h8) |-> (mixed.src != SRC_YUV && mixed.src != SRC_RGB);
	endproperty
	a_bypIgnored: assert property (p_bypIgnored) else $error("split source in low mode");

	// Same source may sit on bg and a higher layer, so compare against the midground itself
	property p_bgNeverOver;
		@(posedge mclk) disable iff (!rst_n)
			(mgOn && !fgOn && !dskOn) |-> mixed.src == arr.mg.src;
	endproperty
	a_bgNeverOver: assert property (p_bgNeverOver) else $error("background over midground");

	property p_dskWins;
		@(posedge mclk) disable iff (!rst_n)
			(arr.dsk.src != SRC_NONE && keyShows(arr.dsk.key, pixIn, layerMode)) |-> mixed.src == arr.dsk.src;
	endproperty
	a_dskWins: assert property (p_dskWins) else $error("downstream key lost");

	property p_ovlTransparent;
		@(posedge mclk) disable iff (!rst_n)
			(pixIn.overlaySelectInputs == `LM_OVL_NONE) |-> mixed.src != SRC_OVL;
	endproperty
	a_ovlTransparent: assert property (p_ovlTransparent) else $error("overlay shown while clear");

	property p_mode0Key;
		@(posedge mclk) disable iff (!rst_n)
			(layerMode == 4'h0 && !pixIn.keyPin && !pixIn.dataKey) |-> mixed.src == SRC_BUS;
	endproperty
	a_mode0Key: assert property (p_mode0Key) else $error("mode 0 bus not keyed in");

	property p_dataKeyOff;
		@(posedge mclk) disable iff (!rst_n)
			(layerMode == 4'h8 && pixIn.bypassN && !pixIn.keyPin) |-> mixed.src == SRC_BUS;
	endproperty
	a_dataKeyOff: assert property (p_dataKeyOff) else $error("data key not disabled");

	property p_regWrite;
		@(posedge mclk) disable iff (!rst_n)
			(regWrite && regAddr == `LM_REG_LAYER_ASSIGN) |=> ctrl_q == $past(regWdata);
	endproperty
	a_regWrite: assert property (p_regWrite) else $error("control write lost");

	property p_noLoss;
		@(posedge mclk) disable iff (!rst_n)
			(outValid && !outReady) |=> outValid && $stable(pixOut);
	endproperty
	a_noLoss: assert property (p_noLoss) else $error("stalled pixel changed");

	property p_fgOverMg;
		@(posedge mclk) disable iff (!rst_n)
			(fgOn && !dskOn) |-> mixed.src == arr.fg.src;
	endproperty
	a_fgOverMg: assert property (p_fgOverMg) else $error("foreground lost");

	property p_bypShows;
		@(posedge mclk) disable iff (!rst_n)
			(layerMode == 4'h9 && !pixIn.bypassN && pixIn.keyPin
				&& pixIn.overlaySelectInputs == `LM_OVL_NONE) |-> mixed.src == SRC_YUV;
	endproperty
	a_bypShows: assert property (p_bypShows) else $error("bypass layer not keyed in");

	property p_ovlKeyed;
		@(posedge mclk) disable iff (!rst_n)
			(layerMode == 4'h4 && pixIn.keyPin
				&& pixIn.overlaySelectInputs != `LM_OVL_NONE) |-> mixed.src == SRC_OVL;
	endproperty
	a_ovlKeyed: assert property (p_ovlKeyed) else $error("overlay not shown");

	property p_ctrlHold;
		@(posedge mclk) disable iff (!rst_n)
			!(regWrite && regAddr == `LM_REG_LAYER_ASSIGN) |=> $stable(ctrl_q);
	endproperty
	a_ctrlHold: assert property (p_ctrlHold) else $error("layer mode changed unasked");
endmodule : layer_mixer

// file: dv/pixel_source.sv
// Host pixel source model for the layer keying mixer
`timescale 1ns/1ps
module pixel_source
	import layer_mixer_pkg::*;
(
	// Clock and reset
	input  wire logic    mclk,
	input  wire logic    rst_n,
	// Bench request
	input  wire logic    go,
	input  wire pix_in_t pixel,
	// Mixer input side
	output logic         inValid,
	input  wire logic    inReady,
	output pix_in_t      pixIn
);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			inValid <= 1'b0;
			pixIn   <= '0;
		end else if (inValid && inReady) begin
			inValid <= 1'b0;
			// Released lines never keep showing the old pixel
			pixIn   <= ~pixIn;
		end else if (go && !inValid) begin
			inValid <= 1'b1;
			pixIn   <= pixel;
		end
	end
endmodule : pixel_source

// file: dv/test_layer_mixer.sv
// Bench for the layer keying mixer
`timescale 1ns/1ps
module test_layer_mixer
	import layer_mixer_pkg::*;
;
	logic       mclk, rst_n, regWrite, outReady, go, inValid, inReady, outValid;
	logic [7:0] regAddr, regWdata, regRdata;
	pix_in_t    pixel, pixIn;
	pix_out_t   pixOut, got;
	int         n_mismatch, checks_done;

	layer_mixer i_layer_mixer(.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .inValid(inValid), .inReady(inReady), .pixIn(pixIn),
		.outValid(outValid), .outReady(outReady), .pixOut(pixOut));
	pixel_source i_pixel_source(.mclk(mclk), .rst_n(rst_n), .go(go), .pixel(pixel),
		.inValid(inValid), .inReady(inReady), .pixIn(pixIn));

	task check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	task wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge mclk) regWrite <= 1'b0;
	endtask : wreg
	task rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk) regAddr <= a;
		@(negedge mclk) check({16'h0, regRdata}, {16'h0, e});
	endtask : rreg
	// Holds one offer; a refused offer stays pending in the source
	task send(input pix_in_t p, input logic take);
		int n;
		@(posedge mclk) go <= 1'b1;
		pixel <= p;
		@(posedge mclk) go <= 1'b0;
		@(negedge mclk);
		for (n = 0; n < 12 && inValid; n++) @(negedge mclk);
		check({23'h0, inValid}, {23'h0, !take});
		if (take && inValid) report_and_stop;
	endtask : send
	task pop;
		int n;
		n = 0;
		@(negedge mclk);
		while (outValid !== 1'b1 && n < 12) begin
			@(negedge mclk);
			n++;
		end
		if (outValid !== 1'b1) begin
			check(24'h0, 24'h1);
			report_and_stop;
		end
		got = pixOut;
		@(posedge mclk) outReady <= 1'b1;
		@(posedge mclk) outReady <= 1'b0;
	endtask : pop
	task mix(input logic [3:0] m, input logic k, d, b, input logic [4:0] o, input src_t e);
		wreg(8'h04, {4'h0, m});
		send('{24'h12_3456, 8'hA5, o, k, d, b}, 1'b1);
		pop;
		check({21'h0, got.src}, {21'h0, e});
		check({19'h0, got.overlay}, {19'h0, o});
		if (e == SRC_PD || e == SRC_RGB || e == SRC_YUV) check(got.data, 24'h12_3456);
		if (e == SRC_BUS) check(got.data, 24'h00_00A5);
	endtask : mix

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		rst_n = 1'b0;
		regWrite = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		outReady = 1'b0;
		go = 1'b0;
		pixel = '0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rreg(8'h04, 8'h00);
		wreg(8'h04, 8'hA9);
		wreg(8'h05, 8'h33);
		rreg(8'h04, 8'hA9);
		rreg(8'h05, 8'h00);
		$display("register test done");
		mix(4'h0, 1'b0, 1'b0, 1'b1, 5'h00, SRC_BUS);
		mix(4'h0, 1'b1, 1'b0, 1'b1, 5'h00, SRC_PD);
		mix(4'h0, 1'b0, 1'b1, 1'b0, 5'h00, SRC_PD);
		mix(4'h1, 1'b0, 1'b0, 1'b1, 5'h01, SRC_OVL);
		mix(4'h1, 1'b0, 1'b0, 1'b1, 5'h00, SRC_BUS);
		mix(4'h2, 1'b0, 1'b1, 1'b1, 5'h00, SRC_BUS);
		mix(4'h2, 1'b1, 1'b0, 1'b1, 5'h00, SRC_PD);
		mix(4'h3, 1'b1, 1'b1, 1'b1, 5'h10, SRC_OVL);
		mix(4'h4, 1'b1, 1'b0, 1'b1, 5'h03, SRC_OVL);
		mix(4'h4, 1'b1, 1'b0, 1'b1, 5'h00, SRC_BUS);
		mix(4'h5, 1'b1, 1'b0, 1'b1, 5'h00, SRC_BUS);
		mix(4'h6, 1'b0, 1'b0, 1'b1, 5'h00, SRC_PD);
		mix(4'h7, 1'b0, 1'b1, 1'b1, 5'h00, SRC_BUS);
		mix(4'h8, 1'b0, 1'b1, 1'b1, 5'h00, SRC_BUS);
		mix(4'h8, 1'b1, 1'b0, 1'b0, 5'h00, SRC_YUV);
		mix(4'hA, 1'b1, 1'b0, 1'b0, 5'h00, SRC_YUV);
		mix(4'hB, 1'b1, 1'b0, 1'b1, 5'h04, SRC_OVL);
		mix(4'hE, 1'b0, 1'b0, 1'b1, 5'h00, SRC_RGB);
		mix(4'h9, 1'b1, 1'b0, 1'b0, 5'h00, SRC_YUV);
		mix(4'h9, 1'b1, 1'b0, 1'b1, 5'h00, SRC_RGB);
		mix(4'h9, 1'b0, 1'b1, 1'b1, 5'h00, SRC_BUS);
		mix(4'h9, 1'b0, 1'b1, 1'b0, 5'h00, SRC_YUV);
		mix(4'hC, 1'b0, 1'b0, 1'b1, 5'h00, SRC_BUS);
		mix(4'hD, 1'b0, 1'b0, 1'b1, 5'h00, SRC_RGB);
		mix(4'hF, 1'b1, 1'b0, 1'b0, 5'h01, SRC_YUV);
		mix(4'hF, 1'b1, 1'b0, 1'b1, 5'h00, SRC_RGB);
		$display("mixing test done");
		// Receiver stalls: third pixel must wait, none may be lost
		wreg(8'h04, 8'h00);
		send('{24'h00_0001, 8'h00, 5'h00, 1'b1, 1'b0, 1'b1}, 1'b1);
		send('{24'h00_0002, 8'h00, 5'h00, 1'b1, 1'b0, 1'b1}, 1'b1);
		send('{24'h00_0003, 8'h00, 5'h00, 1'b1, 1'b0, 1'b1}, 1'b0);
		pop;
		check(got.data, 24'h00_0001);
		pop;
		check(got.data, 24'h00_0002);
		pop;
		check(got.data, 24'h00_0003);
		$display("buffer test done");
		report_and_stop;
	end
endmodule : test_layer_mixer
